// file: qrcl_core.v
/*
 control logic of a four-channel step-down regulator: run pin merging,
 per-regulator mode and setpoint registers loaded from a serial shifter,
 interface-supply undervoltage reset and the power-good reset output.
 assumes scl/sda, wr_strobe and the undervoltage pin are synchronous to clk; framing of the
 serial protocol is outside this block, wr_strobe marks a complete word.
 run pins and the good comparator pass two synchroniser stages; run pins reach reg_en_r
 three clock edges late, and a good drop reaches power_good_reset_oe_n four edges late.
*/
// Summary of operation
// [RULE_01] enable is run pin OR serial bit
// [RULE_02] large run low-active, small high-active
// [RULE_03] run pin enable gives defaults
// [RULE_04] serial writes apply while running
// [RULE_05] 16-step feedback code, 425 to 800mV
// [RULE_06] 128-level output code per regulator
// [RULE_07] power-good released after 230ms good
// [RULE_08] power-good low below 92%, restart delay
// [RULE_09] undervoltage forces all settings to default
// [RULE_10] one bit shifted per serial clock
// [RULE_11] four selectable operating modes
// [RULE_12] separate state for each regulator
// [RULE_13] feedback code low four bits decode
// [RULE_14] output code seven bits, zero lowest
// [RULE_15] output regulators off at power-up
// [RULE_16] sync pins, counter-timed release delay
`timescale 1ns/1ps
`default_nettype none
`include "qrcl_defines.vh"

module qrcl_core #(
    parameter [`QRCL_POR_CNT_W-1:0] POR_DELAY_CYC = `QRCL_POR_DELAY_CYC
) (
    input wire clk,
    input wire srst,
    input wire large_fb_reg_run_n,
    input wire small_fb_reg_run,
    input wire supply_undervoltage_detect,
    input wire large_fb_in_reg,
    input wire scl,
    input wire sda,
    input wire wr_strobe,
    output reg [3:0] reg_en_r,
    output reg [7:0] reg_mode_r,
    output reg [`QRCL_FB_CODE_W-1:0] large_fb_code_r,
    output reg [`QRCL_FB_CODE_W-1:0] small_fb_code_r,
    output reg [`QRCL_OUT_CODE_W-1:0] large_out_code_r,
    output reg [`QRCL_OUT_CODE_W-1:0] small_out_code_r,
    output reg [9:0] large_fb_mv_r,
    output reg [9:0] small_fb_mv_r,
    output reg power_good_reset_out,
    output reg power_good_reset_oe_n
);
    // serial word: [15:14] regulator, [13] enable, [12:11] mode, [10:4] code, [3:0] unused
    reg [15:0] shift_r;
    reg scl_d_r;
    reg run_l_s1_r;
    reg run_l_s2_r;
    reg run_s_s1_r;
    reg run_s_s2_r;
    reg pg_s1_r;
    reg pg_s2_r;
    reg [3:0] ser_en_r;
    reg [7:0] ser_mode_r;
    reg [`QRCL_FB_CODE_W-1:0] ser_fb_l_r;
    reg [`QRCL_FB_CODE_W-1:0] ser_fb_s_r;
    reg [`QRCL_OUT_CODE_W-1:0] ser_out_l_r;
    reg [`QRCL_OUT_CODE_W-1:0] ser_out_s_r;
    reg [3:0] ser_written_r;
    reg [3:0] reg_en_nxt;
    reg [`QRCL_FB_CODE_W-1:0] large_fb_code_nxt;
    reg [`QRCL_FB_CODE_W-1:0] small_fb_code_nxt;
    reg [9:0] large_fb_mv_nxt;
    reg [9:0] small_fb_mv_nxt;
    wire por_release;
    wire run_large;
    wire run_small;

    function [9:0] fb_mv;
        input [`QRCL_FB_CODE_W-1:0] code;
        begin
            // [RULE_13] low nibble decode
            fb_mv = `QRCL_FB_MIN_MV + code * `QRCL_FB_STEP_MV;
        end
    endfunction

    function [`QRCL_FB_CODE_W-1:0] fb_code_sel;
        input written;
        input [`QRCL_FB_CODE_W-1:0] code;
        begin
            // [RULE_03] full scale until written
            fb_code_sel = written ? code : `QRCL_FB_CODE_FULL;
        end
    endfunction

    // [RULE_16] two-stage synchronisers
    always @(posedge clk) begin
        if (srst) begin
            run_l_s1_r <= 1'b1;
            run_l_s2_r <= 1'b1;
            run_s_s1_r <= 1'b0;
            run_s_s2_r <= 1'b0;
            pg_s1_r <= 1'b0;
            pg_s2_r <= 1'b0;
        end else begin
            run_l_s1_r <= large_fb_reg_run_n;
            run_l_s2_r <= run_l_s1_r;
            run_s_s1_r <= small_fb_reg_run;
            run_s_s2_r <= run_s_s1_r;
            pg_s1_r <= large_fb_in_reg;
            pg_s2_r <= pg_s1_r;
        end
    end

    // [RULE_02] pin polarities
    assign run_large = ~run_l_s2_r;
    assign run_small = run_s_s2_r;

    // the word is only taken on wr_strobe, so stray bits between frames are harmless
    // [RULE_10] one bit per rising scl
    always @(posedge clk) begin
        if (srst) begin
            // scl idles high; resetting to that level avoids a false edge after reset
            scl_d_r <= 1'b1;
            shift_r <= 16'h0000;
        end else begin
            scl_d_r <= scl;
            if (scl && !scl_d_r) begin
                shift_r <= {shift_r[14:0], sda};
            end
        end
    end

    // a write that meets undervoltage is dropped: the clear always wins
    // [RULE_09] undervoltage clears settings
    always @(posedge clk) begin
        if (srst || supply_undervoltage_detect) begin
            // [RULE_15] output regulators start disabled
            ser_en_r <= 4'h0;
            ser_mode_r <= {4{`QRCL_MODE_PULSE_SKIP}};
            ser_fb_l_r <= `QRCL_FB_CODE_FULL;
            ser_fb_s_r <= `QRCL_FB_CODE_FULL;
            ser_out_l_r <= `QRCL_OUT_CODE_DEF;
            ser_out_s_r <= `QRCL_OUT_CODE_DEF;
            ser_written_r <= 4'h0;
        // [RULE_04] applied on the fly
        end else if (wr_strobe) begin
            // [RULE_12] only the addressed regulator
            ser_en_r[shift_r[15:14]] <= shift_r[13];
            // [RULE_11] mode field
            ser_mode_r[shift_r[15:14]*2 +: 2] <= shift_r[12:11];
            ser_written_r[shift_r[15:14]] <= 1'b1;
            case (shift_r[15:14])
                `QRCL_IDX_LARGE_FB: ser_fb_l_r <= shift_r[7:4];
                `QRCL_IDX_SMALL_FB: ser_fb_s_r <= shift_r[7:4];
                // [RULE_14] seven-bit output code
                `QRCL_IDX_LARGE_OUT: ser_out_l_r <= shift_r[10:4];
                default: ser_out_s_r <= shift_r[10:4];
            endcase
        end
    end

    // [RULE_01] pin OR serial enable
    always @* begin
        reg_en_nxt = {ser_en_r[3:2], ser_en_r[1] | run_small, ser_en_r[0] | run_large};
        // [RULE_03] defaults until written
        large_fb_code_nxt = fb_code_sel(ser_written_r[0], ser_fb_l_r);
        small_fb_code_nxt = fb_code_sel(ser_written_r[1], ser_fb_s_r);
        // [RULE_05] setpoint in millivolts
        large_fb_mv_nxt = fb_mv(large_fb_code_nxt);
        small_fb_mv_nxt = fb_mv(small_fb_code_nxt);
    end

    // run pin enable without a serial write keeps defaults
    always @(posedge clk) begin
        if (srst) begin
            reg_en_r <= 4'h0;
            reg_mode_r <= {4{`QRCL_MODE_PULSE_SKIP}};
            large_fb_code_r <= `QRCL_FB_CODE_FULL;
            small_fb_code_r <= `QRCL_FB_CODE_FULL;
            large_out_code_r <= `QRCL_OUT_CODE_DEF;
            small_out_code_r <= `QRCL_OUT_CODE_DEF;
            large_fb_mv_r <= `QRCL_FB_MV_FULL;
            small_fb_mv_r <= `QRCL_FB_MV_FULL;
        end else begin
            reg_en_r <= reg_en_nxt;
            // [RULE_11] mode per regulator
            reg_mode_r <= ser_mode_r;
            large_fb_code_r <= large_fb_code_nxt;
            small_fb_code_r <= small_fb_code_nxt;
            // [RULE_06] output codes
            large_out_code_r <= ser_out_l_r;
            small_out_code_r <= ser_out_s_r;
            large_fb_mv_r <= large_fb_mv_nxt;
            small_fb_mv_r <= small_fb_mv_nxt;
        end
    end

    // [RULE_16] counter-timed release
    qrcl_por_timer #(.DELAY_CYC(POR_DELAY_CYC)) u_por (
        .clk(clk),
        .srst(srst),
        // a disabled rail never counts as good
        .in_reg(pg_s2_r & reg_en_r[0]),
        .release_r(por_release)
    );

    // the data bit stays low; only the enable moves, as an open-drain pin needs
    // [RULE_07] open drain: enable low pulls low
    always @(posedge clk) begin
        if (srst) begin
            power_good_reset_out <= 1'b0;
            power_good_reset_oe_n <= 1'b0;
        end else begin
            power_good_reset_out <= 1'b0;
            power_good_reset_oe_n <= por_release;
        end
    end
endmodule
`default_nettype wire

// file: qrcl_defines.vh
/*
 constants for the quad regulator control logic: mode codes, setpoint widths,
 default values and timing counts. assumes a 10 MHz core clock.
*/
`ifndef QRCL_DEFINES_VH
`define QRCL_DEFINES_VH

`define QRCL_CLK_HZ 24'h989680
`define QRCL_MODE_W 2
`define QRCL_MODE_PULSE_SKIP 2'h0
`define QRCL_MODE_AUTO_HYST 2'h1
`define QRCL_MODE_FORCED_HYST 2'h2
`define QRCL_MODE_LDO 2'h3
`define QRCL_FB_CODE_W 4
`define QRCL_OUT_CODE_W 7
`define QRCL_FB_CODE_FULL 4'hf
`define QRCL_FB_CODE_MIN 4'h0
`define QRCL_OUT_CODE_DEF 7'h00
`define QRCL_FB_MIN_MV 10'h1a9
`define QRCL_FB_STEP_MV 10'h019
`define QRCL_FB_MV_FULL 10'h320
`define QRCL_OUT_MIN_MV 12'h258
`define QRCL_OUT_STEP_MV 12'h019
`define QRCL_POR_DELAY_MS 8'he6
// release delay in core clock cycles: 230 ms at 10 MHz
`define QRCL_POR_DELAY_CYC 22'h231860
`define QRCL_POR_CNT_W 22
`define QRCL_NREG 4
`define QRCL_IDX_LARGE_FB 2'h0
`define QRCL_IDX_SMALL_FB 2'h1
`define QRCL_IDX_LARGE_OUT 2'h2
`define QRCL_IDX_SMALL_OUT 2'h3

`endif

// file: qrcl_por_timer.v
/*
 power-good reset timer for the large feedback regulator.
 assumes the comparator level arrives already synchronised to clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "qrcl_defines.vh"

module qrcl_por_timer #(
    parameter [`QRCL_POR_CNT_W-1:0] DELAY_CYC = `QRCL_POR_DELAY_CYC
) (
    input wire clk,
    input wire srst,
    input wire in_reg,
    output reg release_r
);
    reg [`QRCL_POR_CNT_W-1:0] cnt_r;

    always @(posedge clk) begin
        if (srst) begin
            cnt_r <= {`QRCL_POR_CNT_W{1'b0}};
            release_r <= 1'b0;
        // [RULE_08] drop and restart
        end else if (!in_reg) begin
            cnt_r <= {`QRCL_POR_CNT_W{1'b0}};
            release_r <= 1'b0;
        // [RULE_07] release after delay
        end else if (cnt_r >= DELAY_CYC - 1'b1) begin
            release_r <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: qrcl_props.sv
/* assertions on the qrcl_core ports.
 assumes one clock domain and srst synchronous, active high. */
`timescale 1ns/1ps
`default_nettype none
module qrcl_props #(parameter [21:0] POR_DELAY_CYC = 22'd20) (
    input wire logic clk,
    input wire logic srst,
    input wire logic large_fb_reg_run_n,
    input wire logic small_fb_reg_run,
    input wire logic supply_undervoltage_detect,
    input wire logic large_fb_in_reg,
    input wire logic [3:0] reg_en_r,
    input wire logic [7:0] reg_mode_r,
    input wire logic [3:0] large_fb_code_r,
    input wire logic [6:0] large_out_code_r,
    input wire logic [9:0] large_fb_mv_r,
    input wire logic power_good_reset_out,
    input wire logic power_good_reset_oe_n
);
    logic [21:0] good_r;
    // raw good time; the synchroniser only adds to it
    always @(posedge clk) begin
        if (srst || !large_fb_in_reg)
            good_r <= 22'h0;
        else if (good_r != 22'h3fffff)
            good_r <= good_r + 22'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    chk_od_data_low: assert property (!power_good_reset_out) else $error("pg data not low");
    chk_pg_wait: assert property ($rose(power_good_reset_oe_n) |-> good_r >= POR_DELAY_CYC)
        else $error("pg released early");
    chk_pg_drop: assert property (!large_fb_in_reg [*6] |-> !power_good_reset_oe_n)
        else $error("pg not pulled low");
    chk_large_run: assert property (!large_fb_reg_run_n [*4] |-> reg_en_r[0])
        else $error("large run ignored");
    chk_small_run: assert property (small_fb_reg_run [*4] |-> reg_en_r[1])
        else $error("small run ignored");
    chk_uv_clear: assert property (supply_undervoltage_detect [*3] |->
        reg_en_r[3:2] == 2'h0 && reg_mode_r == 8'h00 && large_out_code_r == 7'h00) else $error("uv not cleared");
    chk_fb_mv: assert property ($stable(large_fb_code_r) |->
        large_fb_mv_r == 10'd425 + 10'd25 * large_fb_code_r) else $error("fb mv wrong");
    chk_out_off: assert property ($fell(srst) |-> reg_en_r[3:2] == 2'h0) else $error("out reg on");
endmodule
bind qrcl_core qrcl_props #(.POR_DELAY_CYC(POR_DELAY_CYC)) u_props (
    .clk(clk),
    .srst(srst),
    .large_fb_reg_run_n(large_fb_reg_run_n),
    .small_fb_reg_run(small_fb_reg_run),
    .supply_undervoltage_detect(supply_undervoltage_detect),
    .large_fb_in_reg(large_fb_in_reg),
    .reg_en_r(reg_en_r),
    .reg_mode_r(reg_mode_r),
    .large_fb_code_r(large_fb_code_r),
    .large_out_code_r(large_out_code_r),
    .large_fb_mv_r(large_fb_mv_r),
    .power_good_reset_out(power_good_reset_out),
    .power_good_reset_oe_n(power_good_reset_oe_n)
);
`default_nettype wire

// file: qrcl_host.sv
/* serial host model: shifts 16 bit words msb first, then strobes.
 assumes scl and sda idle high, as with bus pull-ups. */
`timescale 1ns/1ps
`default_nettype none
module qrcl_host (
    input wire logic clk,
    output logic scl,
    output logic sda,
    output logic wr_strobe
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
        wr_strobe = 1'b0;
    end
    task automatic send(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            @(posedge clk);
            #1 scl = 1'b0;
            sda = w[i];
            repeat (2) @(posedge clk);
            #1 scl = 1'b1;
            repeat (2) @(posedge clk);
        end
        #1 wr_strobe = 1'b1;
        @(posedge clk);
        #1 wr_strobe = 1'b0;
        sda = 1'b1;
    endtask
endmodule
`default_nettype wire

// file: qrcl_core_tb.sv
/* self-checking bench for qrcl_core with a short release delay.
 assumes qrcl_host on the serial pins and qrcl_props bound in. */
`timescale 1ns/1ps
`default_nettype none
module qrcl_core_tb;
    logic clk, srst, run_n, run, uv, in_reg;
    wire scl, sda, wr_strobe, pgo, pgoe_n;
    wire [3:0] en, lfc, sfc;
    wire [7:0] mode;
    wire [6:0] loc, soc;
    wire [9:0] lmv, smv;
    int fails = 0;
    int total_checks = 0;
    logic [6:0] cv [4] = '{7'h70, 7'h7e, 7'h7f, 7'h00};
    qrcl_host u_host (.clk(clk), .scl(scl), .sda(sda), .wr_strobe(wr_strobe));
    qrcl_core #(.POR_DELAY_CYC(22'd20)) u_dut (.clk(clk), .srst(srst), .large_fb_reg_run_n(run_n),
        .small_fb_reg_run(run), .supply_undervoltage_detect(uv), .large_fb_in_reg(in_reg), .scl(scl),
        .sda(sda), .wr_strobe(wr_strobe), .reg_en_r(en), .reg_mode_r(mode), .large_fb_code_r(lfc),
        .small_fb_code_r(sfc), .large_out_code_r(loc), .small_out_code_r(soc), .large_fb_mv_r(lmv),
        .small_fb_mv_r(smv), .power_good_reset_out(pgo), .power_good_reset_oe_n(pgoe_n));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic summarize;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic t_reset;
        chk("en", 4'h0, en);
        chk("mode", 8'h00, mode);
        chk("lmv", 10'd800, lmv);
        chk("oe", 1'b0, pgoe_n);
    endtask
    task automatic t_run;
        run_n = 1'b0;
        tick(4);
        chk("en", 4'h1, en);
        chk("lfc", 4'hf, lfc);
        run = 1'b1;
        tick(4);
        chk("en", 4'h3, en);
        run = 1'b0;
        tick(4);
        chk("en", 4'h1, en);
    endtask
    task automatic t_write;
        for (int i = 0; i < 4; i++) begin
            u_host.send({i[1:0], 1'b1, i[1:0], cv[i], 4'h0});
            tick(3);
            if (i == 0)
                chk("lmv", 10'd425, lmv);
        end
        chk("en", 4'hf, en);
        chk("mode", 8'he4, mode);
        chk("lfc", 4'h0, lfc);
        chk("sfc", 4'he, sfc);
        chk("smv", 10'd775, smv);
        chk("loc", 7'h7f, loc);
        chk("soc", 7'h00, soc);
    endtask
    task automatic t_uv;
        uv = 1'b1;
        u_host.send(16'ha550);
        tick(3);
        chk("en", 4'h1, en);
        chk("lfc", 4'hf, lfc);
        chk("loc", 7'h00, loc);
        uv = 1'b0;
    endtask
    task automatic t_pg;
        int n;
        in_reg = 1'b1;
        for (n = 0; n < 40 && pgoe_n !== 1'b1; n++)
            tick(1);
        chk("pg delay", 1'b1, n >= 20 && n <= 26);
        in_reg = 1'b0;
        tick(1);
        in_reg = 1'b1;
        tick(12);
        chk("oe", 1'b0, pgoe_n);
        chk("pgo", 1'b0, pgo);
    endtask
    initial begin
        #300000;
        fails++;
        summarize;
    end
    initial begin
        srst = 1'b1;
        run_n = 1'b1;
        run = 1'b0;
        uv = 1'b0;
        in_reg = 1'b0;
        tick(6);
        srst = 1'b0;
        tick(1);
        t_reset;
        t_run;
        t_write;
        t_uv;
        t_pg;
        summarize;
    end
endmodule
`default_nettype wire
